// >>> hdl/eec_fifo.sv
/*
  Flop-based FIFO with valid and ready on both sides.
  Assumes one clock for both sides.
*/
`timescale 1ns/10ps
module eec_fifo
  import eec_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // Storage and pointers
  // ==========================================================
  logic [W-1:0] mem_reg [DEPTH]; // Entries
  logic [W-1:0] mem_next [DEPTH];
  logic [AW:0] wp_reg, wp_next; // Write pointer with wrap bit
  logic [AW:0] rp_reg, rp_next; // Read pointer with wrap bit
  logic push, pop;
  // Full when pointers differ only in wrap bit
  assign in_ready = (wp_reg != {~rp_reg[AW], rp_reg[AW-1:0]});
  assign out_valid = (wp_reg != rp_reg);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rp_reg[AW-1:0]];
  // Next pointers and entry write
  always_comb
  begin
    mem_next = mem_reg;
    if (push)
    begin
      mem_next[wp_reg[AW-1:0]] = in_data;
    end
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
  end
  // Registers; entries need no reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    mem_reg <= mem_next;
  end
endmodule // eec_fifo

// >>> hdl/eec_host.sv
/*
  Bus host for a two-wire serial memory: byte and page writes with
  acknowledge polling, random and current-address sequential reads.
  Assumes open-drain wires resolved outside, pulled up when released.
*/
`timescale 1ns/10ps
module eec_host
  import eec_pkg::*;
#(
  parameter logic [3:0] DEV_CODE = 4'h5, // Arbitrary value, set per system
  parameter int WC_CYC = WRITE_CYCLE_CYC // Polling give-up time in cycles
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eec_cmd_t cmd,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic done,
  output logic err,
  output logic busy,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic wp_o
);
  localparam int WCW = $clog2(WC_CYC + 1);
  // ==========================================================
  // Types and state
  // ==========================================================
  typedef enum logic [3:0] {ST_IDLE, ST_RS_LO, ST_RS_HI, ST_START, ST_BIT_LO,
    ST_BIT_HI, ST_STOP_LO, ST_STOP_HI, ST_GAP} eec_state_t;
  typedef enum logic [2:0] {STG_DEVW, STG_AHI, STG_ALO, STG_WDAT, STG_DEVR,
    STG_RDAT, STG_POLL} eec_stage_t;
  eec_state_t state_reg, state_next; // Bit-level sequencer
  eec_stage_t stage_reg, stage_next; // Which byte is on the wire
  eec_op_t op_reg, op_next; // Command kind
  logic [7:0] cnt_reg, cnt_next; // Phase timer
  logic [3:0] bit_reg, bit_next; // Bit in byte, eight is acknowledge
  logic [7:0] tx_reg, tx_next; // Outgoing byte, sent from bit seven
  logic [7:0] rx_reg, rx_next; // Incoming byte
  logic [7:0] left_reg, left_next; // Data bytes still to move
  logic [WORD_ADDR_W-1:0] addr_reg, addr_next; // Word address
  logic scl_oe_reg, scl_oe_next; // Clock pulled low
  logic sda_oe_reg, sda_oe_next; // Data pulled low
  logic wp_reg, wp_next; // Protect pin level
  logic rd_valid_reg, rd_valid_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic poll_reg, poll_next; // Waiting for internal write to end
  logic [WCW-1:0] wait_reg, wait_next; // Time spent polling
  eec_pins_t pin_s; // Synchronised wires
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  logic send_stage;
  // ==========================================================
  // Inputs and write buffer
  // ==========================================================
  eec_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din({scl_i, sda_i}),
    .dout(pin_s)
  );
  // Drained only at the first bit of a data byte, so it fills
  eec_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  // ==========================================================
  // Byte chooser
  // ==========================================================
  // Device byte has zero low address bits and the direction bit last
  function automatic logic [7:0] tx_byte(input eec_stage_t stg,
    input logic [WORD_ADDR_W-1:0] adr);
    logic [7:0] b;
    b = {DEV_CODE, 4'h0};
    case (stg)
      STG_DEVR: b = {DEV_CODE, 4'h1};
      STG_AHI: b = {4'h0, adr[11:8]};
      STG_ALO: b = adr[7:0];
      default: b = {DEV_CODE, 4'h0};
    endcase
    return b;
  endfunction
  assign send_stage = (stage_reg != STG_RDAT);
  assign cmd_ready = (state_reg == ST_IDLE);
  assign fifo_pop = (state_reg == ST_BIT_LO) && (stage_reg == STG_WDAT)
    && (bit_reg == 4'h0) && (cnt_reg == 8'h00);
  // ==========================================================
  // Sequencer next state
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    stage_next = stage_reg;
    op_next = op_reg;
    cnt_next = cnt_reg + 8'h01;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    left_next = left_reg;
    addr_next = addr_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    wp_next = wp_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    done_next = 1'b0;
    err_next = err_reg;
    poll_next = poll_reg;
    wait_next = (poll_reg && wait_reg != WCW'(WC_CYC)) ? wait_reg + 1'b1 : wait_reg;
    case (state_reg)
      // Bus released, wait for a command
      ST_IDLE:
      begin
        cnt_next = 8'h00;
        scl_oe_next = 1'b0;
        sda_oe_next = 1'b0;
        if (cmd_valid)
        begin
          op_next = cmd.op;
          addr_next = cmd.addr;
          left_next = (cmd.len == 8'h00) ? 8'h01 : cmd.len;
          wp_next = cmd.protect;
          err_next = 1'b0;
          stage_next = (cmd.op == OP_CUR) ? STG_DEVR : STG_DEVW;
          state_next = ST_RS_LO;
        end
      end
      // Clock low, then data released ahead of a start
      ST_RS_LO:
      begin
        scl_oe_next = 1'b1;
        if (cnt_reg == HOLD_CYC)
        begin
          sda_oe_next = 1'b0;
        end
        if (cnt_reg == LOW_CYC - 8'h01)
        begin
          scl_oe_next = 1'b0;
          cnt_next = 8'h00;
          state_next = ST_RS_HI;
        end
      end
      // Clock high with data high: start setup
      ST_RS_HI:
      begin
        if (!pin_s.scl)
        begin
          cnt_next = cnt_reg; // Someone holds the clock low
        end
        else if (cnt_reg == HIGH_CYC - 8'h01)
        begin
          sda_oe_next = 1'b1;
          cnt_next = 8'h00;
          state_next = ST_START;
        end
      end
      // Start hold, then clock falls for the first bit
      ST_START:
      begin
        if (cnt_reg == HIGH_CYC - 8'h01)
        begin
          scl_oe_next = 1'b1;
          bit_next = 4'h0;
          cnt_next = 8'h00;
          state_next = ST_BIT_LO;
        end
      end
      // Clock low: load byte, then set data after the hold delay
      ST_BIT_LO:
      begin
        if (bit_reg == 4'h0 && cnt_reg == 8'h00)
        begin
          if (stage_reg == STG_WDAT)
          begin
            tx_next = fifo_data;
            cnt_next = fifo_valid ? 8'h01 : 8'h00; // Clock held low while empty
          end
          else
          begin
            tx_next = tx_byte(stage_reg, addr_reg);
          end
        end
        else if (cnt_reg == HOLD_CYC)
        begin
          if (bit_reg == 4'h8)
          begin
            // Release for device ack; after a read byte ack unless last
            sda_oe_next = !send_stage && (left_reg > 8'h01);
          end
          else
          begin
            sda_oe_next = send_stage && !tx_reg[7];
          end
        end
        else if (cnt_reg == LOW_CYC - 8'h01)
        begin
          scl_oe_next = 1'b0;
          cnt_next = 8'h00;
          state_next = ST_BIT_HI;
        end
      end
      // Clock high: sample at the end of the high time
      ST_BIT_HI:
      begin
        if (!pin_s.scl)
        begin
          cnt_next = cnt_reg;
        end
        else if (cnt_reg == HIGH_CYC - 8'h01)
        begin
          scl_oe_next = 1'b1;
          cnt_next = 8'h00;
          state_next = ST_BIT_LO;
          if (bit_reg != 4'h8)
          begin
            rx_next = {rx_reg[6:0], pin_s.sda};
            tx_next = {tx_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'h1;
          end
          else
          begin
            bit_next = 4'h0;
            if (!send_stage)
            begin
              rd_valid_next = 1'b1;
              rd_data_next = rx_reg;
              if (left_reg > 8'h01)
              begin
                left_next = left_reg - 8'h01;
              end
              else
              begin
                state_next = ST_STOP_LO;
              end
            end
            else if (pin_s.sda)
            begin
              // No acknowledge: end the frame
              state_next = ST_STOP_LO;
              if (stage_reg != STG_POLL)
              begin
                err_next = 1'b1;
                poll_next = 1'b0;
              end
            end
            else
            begin
              case (stage_reg)
                STG_DEVW: stage_next = STG_AHI;
                STG_AHI: stage_next = STG_ALO;
                STG_ALO:
                begin
                  if (op_reg == OP_WRITE)
                  begin
                    stage_next = STG_WDAT;
                  end
                  else
                  begin
                    stage_next = STG_DEVR;
                    state_next = ST_RS_LO;
                  end
                end
                STG_WDAT:
                begin
                  if (left_reg > 8'h01)
                  begin
                    left_next = left_reg - 8'h01;
                  end
                  else
                  begin
                    state_next = ST_STOP_LO;
                    poll_next = 1'b1;
                    wait_next = '0;
                  end
                end
                STG_DEVR: stage_next = STG_RDAT;
                default:
                begin
                  poll_next = 1'b0;
                  state_next = ST_STOP_LO;
                end
              endcase
            end
          end
        end
      end
      // Clock low, data pulled low ahead of stop
      ST_STOP_LO:
      begin
        if (cnt_reg == HOLD_CYC)
        begin
          sda_oe_next = 1'b1;
        end
        if (cnt_reg == LOW_CYC - 8'h01)
        begin
          scl_oe_next = 1'b0;
          cnt_next = 8'h00;
          state_next = ST_STOP_HI;
        end
      end
      // Clock high, then data released: stop
      ST_STOP_HI:
      begin
        if (!pin_s.scl)
        begin
          cnt_next = cnt_reg;
        end
        else if (cnt_reg == HIGH_CYC - 8'h01)
        begin
          sda_oe_next = 1'b0;
          cnt_next = 8'h00;
          state_next = ST_GAP;
        end
      end
      // Bus free time; then poll again or finish
      ST_GAP:
      begin
        if (cnt_reg == BUF_CYC - 8'h01)
        begin
          cnt_next = 8'h00;
          if (poll_reg && wait_reg != WCW'(WC_CYC))
          begin
            stage_next = STG_POLL;
            state_next = ST_RS_LO;
          end
          else
          begin
            err_next = err_reg || poll_reg; // Write never finished
            poll_next = 1'b0;
            done_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end
  // Registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      stage_reg <= STG_DEVW;
      op_reg <= OP_WRITE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      left_reg <= 8'h00;
      addr_reg <= '0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wp_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      poll_reg <= 1'b0;
      wait_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      stage_reg <= stage_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      left_reg <= left_next;
      addr_reg <= addr_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      wp_reg <= wp_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      done_reg <= done_next;
      err_reg <= err_next;
      poll_reg <= poll_next;
      wait_reg <= wait_next;
    end
  end
  // ==========================================================
  // Outputs
  // ==========================================================
  assign scl_o = 1'b0; // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign wp_o = wp_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign done = done_reg;
  assign err = err_reg;
  assign busy = (state_reg != ST_IDLE);
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  start_cond_a: assert property ($rose(sda_oe_reg) && !scl_oe_reg |->
    state_reg == ST_START) else $error("data fell with clock high outside start");
  stop_cond_a: assert property ($fell(sda_oe_reg) && !scl_oe_reg |->
    state_reg == ST_GAP) else $error("data rose with clock high outside stop");
  data_stable_a: assert property (state_reg == ST_BIT_HI |->
    $stable(sda_oe_reg)) else $error("data moved while clock high");
  ack_release_a: assert property (state_reg == ST_BIT_HI && bit_reg == 4'h8
    && send_stage |-> !sda_oe_reg) else $error("host drove device ack slot");
  dev_code_a: assert property (state_reg == ST_BIT_LO && bit_reg == 4'h0
    && cnt_reg == HOLD_CYC && (stage_reg inside {STG_DEVW, STG_DEVR, STG_POLL})
    |-> tx_reg[7:4] == DEV_CODE) else $error("wrong device code");
  write_dir_a: assert property (state_reg == ST_BIT_HI && bit_reg == 4'h7
    && (stage_reg inside {STG_DEVW, STG_POLL}) |-> sda_oe_reg)
    else $error("write direction bit not zero");
  read_end_a: assert property (state_reg == ST_BIT_HI && bit_reg == 4'h8
    && stage_reg == STG_RDAT |-> sda_oe_reg == (left_reg > 8'h01))
    else $error("read ack or final nack wrong");
  rand_order_a: assert property ($rose(stage_reg == STG_DEVR) && op_reg == OP_RAND
    |-> $past(stage_reg) == STG_ALO && state_reg == ST_RS_LO)
    else $error("random read without address");
  poll_retry_a: assert property (state_reg == ST_GAP && cnt_reg == BUF_CYC - 8'h01
    && poll_reg && wait_reg != WCW'(WC_CYC) |=> state_reg == ST_RS_LO
    && stage_reg == STG_POLL) else $error("poll not repeated");
endmodule // eec_host

// >>> hdl/eec_pkg.sv
/*
  Constants, types and timing counts for the serial memory bus host.
  Assumes a 10 MHz system clock and a pull-up on both bus wires.
*/
// How it works
// - start is data falling while clock high
// - stop is data rising while clock high
// - data changes only while clock low
// - eight bits, receiver pulls ninth low
// - seven address bits, then one direction bit
// - byte write: device, word address, data, stop
// - further bytes without stop fill one page
// - poll with address; acknowledge means write done
// - current read: direction one, data, nack, stop
// - random read: dummy write, repeated start, read
package eec_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_NS = 100; // System clock period
  localparam int T_LOW_NS = 1200; // Least clock low time
  localparam int T_HIGH_NS = 600; // Least clock high, start setup and hold
  localparam int T_BUF_NS = 1200; // Least bus free time after stop
  localparam int T_HOLD_NS = 100; // Data change delay after clock falls
  localparam int WRITE_CYCLE_TIME_MS = 5; // Longest internal write
  // Least times round up to whole cycles
  localparam logic [7:0] LOW_CYC = 8'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HIGH_CYC = 8'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BUF_CYC = 8'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_TIME_MS * 1000000 / CLK_NS;
  // ==========================================================
  // Data path
  // ==========================================================
  localparam int DATA_W = 8; // Bus byte
  localparam int FIFO_DEPTH = 32; // Write data buffer words
  localparam int WORD_ADDR_W = 12; // Word address carried on the bus
  // ==========================================================
  // Types
  // ==========================================================
  // Kinds of transfer the user may ask for
  typedef enum logic [1:0] {OP_WRITE, OP_RAND, OP_CUR} eec_op_t;
  // One user command
  typedef struct packed {
    eec_op_t op; // Transfer kind
    logic protect; // Level for the protect pin
    logic [WORD_ADDR_W-1:0] addr; // Word address
    logic [7:0] len; // Byte count, zero taken as one
  } eec_cmd_t;
  // Bus wire pair
  typedef struct packed {
    logic scl; // Clock wire
    logic sda; // Data wire
  } eec_pins_t;
endpackage

// >>> hdl/eec_sync.sv
/*
  Three-flop input synchroniser, one lane per bit.
  Assumes inputs idle high, like a pulled-up bus.
*/
`timescale 1ns/10ps
module eec_sync
  import eec_pkg::*;
#(
  parameter int W = 2
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // ==========================================================
  // Per-bit chain
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_lane
      logic [2:0] ff_reg; // Chain, first stage read only by second
      logic [2:0] ff_next;
      logic out_reg; // Accepted level
      logic out_next;
      // Shift and accept once stages two and three agree
      always_comb
      begin
        ff_next = {ff_reg[1:0], din[gi]};
        out_next = (ff_reg[1] == ff_reg[2]) ? ff_reg[2] : out_reg;
      end
      // Registers; idle level is high
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          ff_reg <= 3'h7;
          out_reg <= 1'b1;
        end
        else
        begin
          ff_reg <= ff_next;
          out_reg <= out_next;
        end
      end
      assign dout[gi] = out_reg;
    end
  endgenerate
endmodule // eec_sync

// >>> tb/eec_mem_model.sv
/* Device model for the memory host bench.
   Assumes pulled-up wires; pull high holds data low. */
`timescale 1ns/10ps
module eec_mem_model #(
  parameter logic [3:0] CODE = 4'h6 // Arbitrary code
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic wp,
  output logic pull
);
  // ====
  // Array and frame state
  logic [7:0] mem [0:2047];
  logic [7:0] sh, dat; // Shift in, byte out
  logic [10:0] ptr, base; // Pointer, write start
  logic act, wr, mack; // Live frame, data taken, master ack
  int bitn, ph, cnt; // Phase 1 dev, 2-3 address, 4 data, 5 read
  int busy_ns = 60000; // Bench may stretch it
  time wend = 0;
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 8'(i * 3);
    {pull, act, ptr, base} = '0;
  end
  // ====
  // Start: a busy device stays deaf
  always @(negedge sda)
    if (scl)
    begin
      act = ($time >= wend);
      {cnt, pull, wr} = '0;
      bitn = -1; // Clock fall after start opens bit zero
      ph = 1;
    end
  // Stop: commit pointer, launch write
  always @(posedge sda)
    if (scl)
    begin
      if (act && wr)
        wend = $time + busy_ns;
      if (act && wr)
        ptr = (cnt > 15) ? base : {base[10:4], base[3:0] + 4'(cnt)};
      {act, pull} = '0;
    end
  // Sample on rising clock
  always @(posedge scl)
    if (act && bitn < 8 && ph != 5)
      sh = {sh[6:0], sda};
    else if (bitn == 8)
      mack = sda;
  // Drive on falling clock
  always @(negedge scl)
    if (act)
    begin
      bitn = bitn + 1;
      if (ph == 5 && bitn < 8)
        pull = ~dat[7 - bitn];
      else if (bitn == 8)
      begin
        pull = ph != 5 && (ph > 1 || sh[7:4] == CODE);
        act = pull || ph == 5;
        if (ph == 4 && !wp)
          mem[{base[10:4], base[3:0] + 4'(cnt)}] = sh;
        wr = wr || ph == 4;
        cnt = cnt + int'(ph == 4);
      end
      else if (bitn == 9)
      begin
        bitn = 0;
        if (ph == 2)
          base[10:8] = sh[2:0];
        if (ph == 3)
          {base[7:0], ptr} = {sh, base[10:8], sh};
        act = ph != 5 || !mack;
        if (ph == 1 && sh[0])
          ph = 5;
        ph = ph + int'(ph < 4);
        dat = mem[ptr];
        ptr = ptr + 11'(ph == 5 && act);
        pull = act && ph == 5 && !dat[7];
      end
    end
endmodule // eec_mem_model

// >>> tb/tb.sv
/* Bench for the memory host: commands, write data, read back.
   Assumes the model's code equals DEV_CODE. */
`timescale 1ns/10ps
module tb;
  import eec_pkg::*;
  // ====
  // Stimulus, wires and tallies
  logic clk_sys = 0, rstn = 0, cmd_valid = 0, wr_valid = 0;
  eec_cmd_t cmd = '0;
  logic [7:0] wr_data = '0, rd_data;
  logic cmd_ready, wr_ready, rd_valid, done, err, busy, scl_oe, sda_oe, wp_o, pull;
  logic scl, sda;
  logic [7:0] rq[$]; // Bytes read back
  int err_total = 0, n_tests = 0;
  assign scl = ~scl_oe; // Pull-up when released
  assign sda = ~(sda_oe | pull);
  initial forever #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    if (rd_valid)
      rq.push_back(rd_data);
  eec_host #(.DEV_CODE(4'h6), .WC_CYC(2000)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .err(err), .busy(busy), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .wp_o(wp_o));
  eec_mem_model #(.CODE(4'h6)) i_mem (.scl(scl), .sda(sda), .wp(wp_o), .pull(pull));
  // ====
  // Shared tasks
  task automatic summarize;
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Push bytes b, b+1.. holding valid across them
  task automatic fill(input logic [7:0] b, input int n);
    int k;
    wr_valid = 1;
    for (int i = 0; i < n; i++)
    begin
      wr_data = b + 8'(i);
      for (k = 0; k < 50 && wr_ready !== 1'b1; k++)
        @(negedge clk_sys);
      if (k == 50)
      begin
        err_total++;
        summarize();
      end
      else
        @(negedge clk_sys);
    end
    wr_valid = 0;
  endtask
  // One command, issued while idle; waits for done
  task automatic run(input eec_op_t op, input logic p, input logic [11:0] a,
    input logic [7:0] n, input logic e);
    int k;
    rq.delete();
    cmd = '{op, p, a, n};
    cmd_valid = 1;
    @(negedge clk_sys);
    cmd_valid = 0;
    chk({6'h0, busy, cmd_ready}, 8'h02);
    for (k = 0; k < 20000 && done !== 1'b1; k++)
      @(negedge clk_sys);
    if (k == 20000)
    begin
      err_total++;
      summarize();
    end
    else
    begin
      chk({7'h0, err}, {7'h0, e});
      chk({7'h0, wp_o}, {7'h0, p});
      chk({6'h0, busy, cmd_ready}, 8'h01);
      chk(8'(rq.size()), (op == OP_WRITE) ? 8'h00 : n);
    end
  endtask
  // ====
  // Scenarios
  task automatic t_page_roll;
    fill(8'h11, 3);
    run(OP_WRITE, 0, 12'h7fe, 3, 0);
    run(OP_RAND, 0, 12'h7fe, 3, 0);
    chk(rq[0], 8'h11);
    chk(rq[1], 8'h12);
    chk(rq[2], 8'h00);
    run(OP_CUR, 0, 12'h000, 1, 0);
    chk(rq[0], 8'h03);
    run(OP_RAND, 0, 12'h7f0, 1, 0);
    chk(rq[0], 8'h13);
  endtask
  task automatic t_protect;
    fill(8'h5a, 1);
    run(OP_WRITE, 1, 12'h010, 1, 0);
    run(OP_RAND, 1, 12'h010, 1, 0);
    chk(rq[0], 8'h30);
  endtask
  // Full buffer refuses, then drains into a wrapped page
  task automatic t_fill;
    fill(8'h40, 32);
    chk({7'h0, wr_ready}, 8'h00);
    run(OP_WRITE, 0, 12'h100, 32, 0);
    run(OP_RAND, 0, 12'h100, 16, 0);
    for (int i = 0; i < 16; i++)
      chk(rq[i], 8'h50 + 8'(i));
  endtask
  // Device stays busy past the poll limit
  task automatic t_timeout;
    i_mem.busy_ns = 400000;
    fill(8'h77, 1);
    run(OP_WRITE, 0, 12'h020, 1, 1);
  endtask
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rstn = 1;
    t_page_roll();
    t_protect();
    t_fill();
    t_timeout();
    summarize();
  end
endmodule // tb
